// [src/bcps_defs.svh]
// Offsets, field positions and timing counts of the bus control sequencer
`ifndef BCPS_DEFS_SVH
`define BCPS_DEFS_SVH

// ----------------------------------------------------------------
// Clock and times
// ----------------------------------------------------------------
`define BCPS_CLK_PERIOD_NS 10
`define BCPS_HALT_MIN_NS 25000
`define BCPS_RSTI_INIT_NS 10000
`define BCPS_PUP_INIT_NS 12600
`define BCPS_PUP_GAP_NS 110000
// Least times round up to whole cycles
`define BCPS_CYC_UP(ns) (((ns) + `BCPS_CLK_PERIOD_NS - 1) / `BCPS_CLK_PERIOD_NS)
`define BCPS_HALT_CYC `BCPS_CYC_UP(`BCPS_HALT_MIN_NS)
`define BCPS_RSTI_CYC `BCPS_CYC_UP(`BCPS_RSTI_INIT_NS)
`define BCPS_PUP_INIT_CYC `BCPS_CYC_UP(`BCPS_PUP_INIT_NS)
`define BCPS_PUP_GAP_CYC `BCPS_CYC_UP(`BCPS_PUP_GAP_NS)

// ----------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------
`define BCPS_OFS_CTRL 12'h000
`define BCPS_OFS_STATUS 12'h004
`define BCPS_OFS_REFRESH 12'h008
`define BCPS_OFS_TRAP 12'h00c

// Control command bits, write one to fire
`define BCPS_CTRL_RESET_INSTR 0
`define BCPS_CTRL_GO 1
`define BCPS_CTRL_HALT_INSTR 2
`define BCPS_CTRL_INSTR_DONE 3
// Refresh enable bit
`define BCPS_REFRESH_EN 0
`define BCPS_REFRESH_RST 1'b0
// Power-fail trap vector, location 24 octal
`define BCPS_PF_VECTOR 8'h14

`endif

// [src/bcps_pkg.sv]
// Types shared by the bus control sequencer
package bcps_pkg;

    typedef enum logic [2:0] {
        ST_OFF   = 3'b000,
        ST_PULSE = 3'b001,
        ST_GAP   = 3'b011,
        ST_WAIT  = 3'b010,
        ST_RUN   = 3'b110,
        ST_RSTI  = 3'b111
    } bcps_state_e;

    typedef struct packed {
        logic [23:0] rsv;
        logic trap_pending;
        logic debug_mode;
        logic init_active;
        logic pok;
        logic dc_ok;
        bcps_state_e state;
    } bcps_status_s;

endpackage

// [src/bcps_power_seq.sv]
// Bus control lines, power sequencing and power-fail trap with APB access
//
// Overview of operation
// [R1] Refresh strobe marks address phase for refresh
// [R2] Refresh master finishes pass within interval; only the refresh strobe is driven here
// [R3] Each refresh transaction steps to new address; no refresh address is generated here
// [R4] Halt line held 25 us enters debug
// [R5] Bus devices reset while initialize asserted
// [R6] Initialize on reset, power sequencing, go
// [R7] Reset instruction holds initialize 10 us
// [R8] Supply asserts dc ok after stable power
// [R9] Supply power ok needs reserve, holds 3ms
// [R10] Power ok negation means power failing
// [R11] Initialize held while dc ok negated
// [R12] Dc ok rise clears status registers
// [R13] Initialize 12.6 us, then negated 110 us
// [R14] Then wait until power ok asserts
// [R15] Power ok comes 70 ms after dc ok
// [R16] Normal power lasts 3 ms before power-down
// [R17] Power-fail traps after instruction to 24
// [R18] Halt with power ok low restarts power-up
// [R19] Power ok returning completes power-up sequence
// [R20] Synchronise halt and power inputs first
`include "bcps_defs.svh"
`timescale 1ns/10ps
`default_nettype none

module bcps_power_seq
    import bcps_pkg::*;
#(
    parameter int unsigned GAP_CYCLES = `BCPS_PUP_GAP_CYC
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic dc_power_ok,
    input wire logic power_ok,
    input wire logic halt_request_line_n,
    input wire logic bus_addr_phase,
    output logic refresh_strobe_out,
    output logic refresh_strobe_oe_n,
    output logic bus_initialize_line_out,
    output logic bus_initialize_line_oe_n,
    output logic console_debug_mode,
    output logic clear_core_regs,
    output logic trap_req,
    output logic [7:0] trap_vector
);

    localparam logic [13:0] PULSE_LOAD = 14'(`BCPS_PUP_INIT_CYC - 1);
    localparam logic [13:0] RSTI_LOAD = 14'(`BCPS_RSTI_CYC - 1);
    localparam logic [13:0] GAP_LOAD = 14'(GAP_CYCLES - 1);
    localparam logic [11:0] HALT_LAST = 12'(`BCPS_HALT_CYC - 1);

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [1:0] dc_sync;
    logic [1:0] pok_sync;
    logic [1:0] halt_sync;
    logic dc_s;
    logic pok_s;
    logic halt_s;
    logic dc_prev;
    logic pok_prev;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dc_sync <= 2'h0;
            pok_sync <= 2'h0;
            halt_sync <= 2'h3;
        end
        else
        begin
            dc_sync <= {dc_sync[0], dc_power_ok}; // [R20]
            pok_sync <= {pok_sync[0], power_ok}; // [R20]
            halt_sync <= {halt_sync[0], halt_request_line_n}; // [R20]
        end
    end

    assign dc_s = dc_sync[1];
    assign pok_s = pok_sync[1];
    assign halt_s = ~halt_sync[1];

    // Edge detectors look only at the second stage
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dc_prev <= 1'b0;
            pok_prev <= 1'b0;
        end
        else
        begin
            dc_prev <= dc_s;
            pok_prev <= pok_s;
        end
    end

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    logic wr_access;
    logic hit;
    logic refresh_en;
    logic cmd_reset;
    logic cmd_go;
    logic cmd_halt;
    logic cmd_done;
    logic pf_pending;
    bcps_state_e state;
    bcps_status_s status;

    // Zero wait states: read data is captured in the setup cycle
    assign pready = 1'b1;
    assign wr_access = psel & penable & pwrite;
    assign hit = (paddr[11:0] == `BCPS_OFS_CTRL)
               | (paddr[11:0] == `BCPS_OFS_STATUS)
               | (paddr[11:0] == `BCPS_OFS_REFRESH)
               | (paddr[11:0] == `BCPS_OFS_TRAP);
    assign pslverr = psel & penable & ~hit;

    assign cmd_reset = wr_access & (paddr[11:0] == `BCPS_OFS_CTRL)
                     & pwdata[`BCPS_CTRL_RESET_INSTR];
    assign cmd_go = wr_access & (paddr[11:0] == `BCPS_OFS_CTRL)
                  & pwdata[`BCPS_CTRL_GO];
    assign cmd_halt = wr_access & (paddr[11:0] == `BCPS_OFS_CTRL)
                    & pwdata[`BCPS_CTRL_HALT_INSTR];
    assign cmd_done = wr_access & (paddr[11:0] == `BCPS_OFS_CTRL)
                    & pwdata[`BCPS_CTRL_INSTR_DONE];

    always_comb
    begin
        status = '0;
        status.trap_pending = pf_pending;
        status.debug_mode = console_debug_mode;
        status.init_active = ~bus_initialize_line_oe_n;
        status.pok = pok_s;
        status.dc_ok = dc_s;
        status.state = state;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0;
        else if (psel & ~penable & ~pwrite)
        begin
            unique case (paddr[11:0])
                `BCPS_OFS_STATUS: prdata <= status;
                `BCPS_OFS_REFRESH: prdata <= {31'h0, refresh_en};
                `BCPS_OFS_TRAP: prdata <= {24'h0, trap_vector};
                default: prdata <= 32'h0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            refresh_en <= `BCPS_REFRESH_RST;
        else if (wr_access & (paddr[11:0] == `BCPS_OFS_REFRESH))
            refresh_en <= pwdata[`BCPS_REFRESH_EN];
    end

    // ------------------------------------------------------------
    // Refresh strobe
    // ------------------------------------------------------------
    // Open-drain, active low; driven only in the address phase
    assign refresh_strobe_out = 1'b0;
    assign refresh_strobe_oe_n = ~(refresh_en & bus_addr_phase); // [R1]

    // ------------------------------------------------------------
    // Power sequencer
    // ------------------------------------------------------------
    logic [13:0] timer;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state <= ST_OFF;
            timer <= 14'h0;
        end
        else if (!dc_s)
        begin
            state <= ST_OFF; // [R11]
            timer <= 14'h0;
        end
        else
        begin
            unique case (state)
                ST_OFF:
                begin
                    state <= ST_PULSE; // [R13]
                    timer <= PULSE_LOAD;
                end
                ST_PULSE:
                begin
                    if (timer == 14'h0)
                    begin
                        state <= ST_GAP; // [R13]
                        timer <= GAP_LOAD;
                    end
                    else
                        timer <= timer - 14'h1;
                end
                ST_GAP:
                begin
                    if (timer == 14'h0)
                        state <= ST_WAIT;
                    else
                        timer <= timer - 14'h1;
                end
                ST_WAIT:
                begin
                    if (pok_s)
                        state <= ST_RUN; // [R14] [R19]
                end
                ST_RUN:
                begin
                    if (cmd_halt & ~pok_s)
                    begin
                        state <= ST_PULSE; // [R18]
                        timer <= PULSE_LOAD;
                    end
                    else if (cmd_reset | cmd_go)
                    begin
                        state <= ST_RSTI; // [R6] [R7]
                        timer <= RSTI_LOAD;
                    end
                end
                ST_RSTI:
                begin
                    if (timer == 14'h0)
                        state <= ST_RUN;
                    else
                        timer <= timer - 14'h1;
                end
                default:
                begin
                    state <= ST_OFF;
                    timer <= 14'h0;
                end
            endcase
        end
    end

    // Open-drain, active low; pulled low while initialising
    assign bus_initialize_line_out = 1'b0;
    assign bus_initialize_line_oe_n = ~((state == ST_OFF)
                                       | (state == ST_PULSE)
                                       | (state == ST_RSTI)); // [R5] [R6]

    // Core register clear on dc rise or on power-up restart from halt
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            clear_core_regs <= 1'b0;
        else
            clear_core_regs <= (dc_s & ~dc_prev)
                             | (state == ST_RUN & cmd_halt & ~pok_s); // [R12] [R18]
    end

    // ------------------------------------------------------------
    // Halt request and debug mode
    // ------------------------------------------------------------
    // Any glitch of the line restarts the count
    logic [11:0] halt_cnt;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            halt_cnt <= 12'h0;
        else if (!halt_s)
            halt_cnt <= 12'h0;
        else if (halt_cnt != HALT_LAST)
            halt_cnt <= halt_cnt + 12'h1;
    end

    // Entry wins over a go arriving in the same cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            console_debug_mode <= 1'b0;
        else if ((halt_s & (halt_cnt == HALT_LAST))
                 | (state == ST_RUN & cmd_halt & pok_s))
            console_debug_mode <= 1'b1; // [R4]
        else if (cmd_go)
            console_debug_mode <= 1'b0; // [R6]
    end

    // ------------------------------------------------------------
    // Power-fail trap
    // ------------------------------------------------------------
    logic take_trap;

    assign take_trap = pf_pending & cmd_done & (state == ST_RUN);

    // A new failure edge wins over the clear by a taken trap
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pf_pending <= 1'b0;
        else if (pok_prev & ~pok_s & dc_s)
            pf_pending <= 1'b1; // [R10]
        else if (take_trap | ~dc_s)
            pf_pending <= 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            trap_req <= 1'b0;
            trap_vector <= 8'h0;
        end
        else
        begin
            trap_req <= take_trap; // [R17]
            if (take_trap)
                trap_vector <= `BCPS_PF_VECTOR; // [R17]
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_pulse_entry;
        state != ST_PULSE ##1 state == ST_PULSE;
    endsequence

    sequence s_pulse_end;
        state == ST_PULSE && timer == 14'h0 && dc_s;
    endsequence

    a_init_dc_low: assert property (!dc_s |=> !bus_initialize_line_oe_n) // [R11]
        else $error("initialize not held while dc ok low");
    a_dc_clear: assert property ($rose(dc_s) |=> clear_core_regs) // [R12]
        else $error("no register clear after dc ok rise");
    a_pulse_len: assert property (s_pulse_entry |-> timer == PULSE_LOAD
                                  && !bus_initialize_line_oe_n) // [R13]
        else $error("power-up initialize pulse length wrong");
    a_gap_len: assert property (s_pulse_end |=> state == ST_GAP
                                && timer == GAP_LOAD
                                && bus_initialize_line_oe_n) // [R13]
        else $error("power-up gap length wrong");
    a_wait_pok: assert property (state == ST_WAIT && !pok_s
                                 |=> state != ST_RUN) // [R14]
        else $error("left wait without power ok");
    a_rsti_pulse: assert property (state == ST_RUN && cmd_reset && pok_s
                                   && dc_s && !cmd_halt
                                   |=> state == ST_RSTI && timer == RSTI_LOAD
                                   && !bus_initialize_line_oe_n) // [R7]
        else $error("reset instruction initialize wrong");
    a_halt_debug: assert property (halt_s && halt_cnt == HALT_LAST
                                   |=> console_debug_mode) // [R4]
        else $error("halt request did not enter debug");
    a_pf_trap: assert property (take_trap |=> trap_req
                                && trap_vector == `BCPS_PF_VECTOR) // [R17]
        else $error("power-fail trap missing or bad vector");
    a_pf_flag: assert property ($fell(pok_s) && dc_s |=> pf_pending) // [R10]
        else $error("power-fail not flagged");
    a_refresh_drv: assert property (refresh_en && bus_addr_phase
                                    |-> !refresh_strobe_oe_n) // [R1]
        else $error("refresh strobe not driven");

endmodule // bcps_power_seq

`default_nettype wire

// [tb/bcps_supply_model.sv]
// Behavioural supply driving the two power status lines
`timescale 1ns/10ps
`default_nettype none
// ------------------------------
// Supply model
// ------------------------------
module bcps_supply_model #(
    parameter int unsigned POK_DELAY = 200,
    parameter int unsigned POK_HOLD = 50
)
(
    input wire logic pclk,
    input wire logic want_dc,
    input wire logic want_pok,
    output var logic dc_power_ok,
    output var logic power_ok
);
    // Delays shortened from milliseconds to keep runs short
    int unsigned dc_cnt;
    int unsigned pok_cnt;
    initial
    begin
        dc_power_ok = 1'b0;
        power_ok = 1'b0;
        dc_cnt = 0;
        pok_cnt = 0;
    end
    always @(posedge pclk)
    begin
        dc_power_ok <= want_dc;
        dc_cnt <= want_dc ? dc_cnt + 1 : 0;
        pok_cnt <= power_ok ? pok_cnt + 1 : 0;
        if (!want_dc)
            power_ok <= 1'b0;
        else if (want_pok && !power_ok && dc_cnt >= POK_DELAY)
            power_ok <= 1'b1;
        else if (!want_pok && power_ok && pok_cnt >= POK_HOLD)
            power_ok <= 1'b0;
    end
endmodule // bcps_supply_model
`default_nettype wire

// [tb/tb.sv]
// Self-checking bench of the bus control sequencer
`include "bcps_defs.svh"
`timescale 1ns/10ps
`default_nettype none
// ------------------------------
// Bench
// ------------------------------
module tb
    import bcps_pkg::*;
;
    localparam int unsigned GAP = 20;
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, pready, pslverr;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic dc_power_ok, power_ok, halt_n, aph, want_dc, want_pok, err;
    logic ref_out, ref_oe_n, ini_out, ini_oe_n, dbg, clr, trq;
    logic [7:0] tvec;
    int miscompares = 0;
    int cmp_count = 0;
    // Open-drain lines float high when nobody pulls them
    wire logic ini_line = ini_oe_n ? 1'b1 : ini_out;
    wire logic ref_line = ref_oe_n ? 1'b1 : ref_out;

    always #5 pclk = ~pclk;

    bcps_supply_model u_supply (.pclk(pclk), .want_dc(want_dc),
        .want_pok(want_pok), .dc_power_ok(dc_power_ok),
        .power_ok(power_ok));

    bcps_power_seq #(.GAP_CYCLES(GAP)) u_dut (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .dc_power_ok(dc_power_ok), .power_ok(power_ok),
        .halt_request_line_n(halt_n), .bus_addr_phase(aph),
        .refresh_strobe_out(ref_out), .refresh_strobe_oe_n(ref_oe_n),
        .bus_initialize_line_out(ini_out),
        .bus_initialize_line_oe_n(ini_oe_n),
        .console_debug_mode(dbg), .clear_core_regs(clr),
        .trap_req(trq), .trap_vector(tvec));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Holds the request until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {20'h0, a};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 100);
        chk({31'h0, pready}, 32'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic count_low(output int n);
        n = 0;
        while (ini_line === 1'b0 && n < 20000)
        begin
            @(posedge pclk);
            #1;
            n++;
        end
    endtask

    task automatic pulses(input bit tr, output int n);
        n = 0;
        #1;
        repeat (4)
        begin
            if ((tr ? trq : clr) === 1'b1)
                n++;
            @(posedge pclk);
            #1;
        end
    endtask

    task automatic wait_state(input bcps_state_e s, input int lim);
        for (int i = 0; i < lim; i++)
        begin
            apb(1'b0, `BCPS_OFS_STATUS, 32'h0);
            if (rd[2:0] === s)
                break;
        end
    endtask

    task automatic t_powerup;
        int n;
        #1;
        chk(ini_line, 1'b0);
        apb(1'b0, `BCPS_OFS_STATUS, 32'h0);
        chk(rd[2:0], ST_OFF);
        want_dc <= 1'b1;
        n = 0;
        while (clr !== 1'b1 && n < 50)
        begin
            @(posedge pclk);
            #1;
            n++;
        end
        chk(clr, 1'b1);
        // The pulse state starts in the same cycle as the clear pulse
        count_low(n);
        chk(n, `BCPS_PUP_INIT_CYC);
        n = 0;
        repeat (GAP)
        begin
            n += (ini_line === 1'b1);
            @(posedge pclk);
            #1;
        end
        chk(n, GAP);
        apb(1'b0, `BCPS_OFS_STATUS, 32'h0);
        chk(rd[2:0], ST_WAIT);
        want_pok <= 1'b1;
        wait_state(ST_RUN, 100);
        chk(rd[2:0], ST_RUN);
        $display("test powerup done");
    endtask

    task automatic t_halt;
        int n;
        @(posedge pclk);
        halt_n <= 1'b0;
        repeat (2490) @(posedge pclk);
        #1;
        chk(dbg, 1'b0);
        n = 0;
        while (dbg !== 1'b1 && n < 30)
        begin
            @(posedge pclk);
            #1;
            n++;
        end
        chk(dbg, 1'b1);
        @(posedge pclk);
        halt_n <= 1'b1;
        $display("test halt done");
    endtask

    // Go first, so that it also leaves debug mode
    task automatic t_init_cmds;
        int n;
        for (int i = 0; i < 2; i++)
        begin
            apb(1'b1, `BCPS_OFS_CTRL,
                32'h1 << (i == 0 ? `BCPS_CTRL_GO : `BCPS_CTRL_RESET_INSTR));
            #1;
            chk(dbg, 1'b0);
            count_low(n);
            chk(n, `BCPS_RSTI_CYC);
        end
        $display("test init commands done");
    endtask

    task automatic t_refresh;
        apb(1'b0, `BCPS_OFS_REFRESH, 32'h0);
        chk(rd, {31'h0, `BCPS_REFRESH_RST});
        apb(1'b0, 12'h010, 32'h0);
        chk({rd[30:0], err}, 32'h1);
        // One address phase, first with refresh disabled, then with it enabled
        aph <= 1'b1;
        @(posedge pclk);
        #1;
        chk(ref_line, 1'b1);
        apb(1'b1, `BCPS_OFS_REFRESH, 32'h1);
        #1;
        chk(ref_line, 1'b0);
        @(posedge pclk);
        aph <= 1'b0;
        #1;
        chk(ref_line, 1'b1);
        apb(1'b1, `BCPS_OFS_REFRESH, 32'h0);
        $display("test refresh done");
    endtask

    task automatic t_powerfail;
        int n;
        @(posedge pclk);
        want_pok <= 1'b0;
        repeat (10) @(posedge pclk);
        apb(1'b0, `BCPS_OFS_STATUS, 32'h0);
        chk(rd[7], 1'b1);
        apb(1'b1, `BCPS_OFS_CTRL, 32'h1 << `BCPS_CTRL_INSTR_DONE);
        pulses(1'b1, n);
        chk(n, 1);
        chk(tvec, `BCPS_PF_VECTOR);
        apb(1'b0, `BCPS_OFS_TRAP, 32'h0);
        chk(rd, {24'h0, `BCPS_PF_VECTOR});
        apb(1'b1, `BCPS_OFS_CTRL, 32'h1 << `BCPS_CTRL_HALT_INSTR);
        pulses(1'b0, n);
        chk(n, 1);
        chk(ini_line, 1'b0);
        @(posedge pclk);
        want_pok <= 1'b1;
        wait_state(ST_RUN, 1000);
        chk(rd[2:0], ST_RUN);
        want_dc <= 1'b0;
        repeat (4) @(posedge pclk);
        #1;
        chk(ini_line, 1'b0);
        $display("test powerfail done");
    endtask

    task automatic results;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial
    begin
        presetn = 1'b0;
        {psel, penable, pwrite, aph, want_dc, want_pok} = 6'h0;
        {paddr, pwdata} = 64'h0;
        halt_n = 1'b1;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_powerup();
        t_halt();
        t_init_cmds();
        t_refresh();
        t_powerfail();
        results();
    end

    // All tests need about 7200 cycles; allow over five times that
    initial
    begin
        #400000;
        miscompares++;
        results();
    end
endmodule // tb
`default_nettype wire
